/* File: rtl/hbd_pkg.sv */
// constants, field layouts and types for the dual h-bridge drive controller
// assumes a single 25 MHz clock; every time below becomes a cycle count from it

package hbd_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_MHZ = 25;
   localparam int CNT_W = 10;
   localparam int BLANK_NS = 3750;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int DEG_NS = 3000;
   localparam int DEG_CYC = (DEG_NS * CLK_MHZ + 999) / 1000;
   localparam int DEAD_NS = 200;
   localparam int DEAD_CYC_RAW = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int DEAD_CYC = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;
   localparam int CHOP_KHZ = 50;
   localparam int CHOP_CYC = (CLK_MHZ * 1000) / CHOP_KHZ;
   localparam int MIX_PCT = 75;
   localparam int MIX_CYC = (CHOP_CYC * MIX_PCT) / 100;

   localparam logic [CNT_W-1:0] BLANK_LD = CNT_W'(BLANK_CYC);
   localparam logic [CNT_W-1:0] DEG_LD = CNT_W'(DEG_CYC);
   localparam logic [CNT_W-1:0] DEAD_LD = CNT_W'(DEAD_CYC);
   localparam logic [CNT_W-1:0] CHOP_LAST = CNT_W'(CHOP_CYC - 1);
   localparam logic [CNT_W-1:0] MIX_LD = CNT_W'(MIX_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

   // ==========================================================
   // register map
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam int CTRL_DECAY_LSB = 0;
   localparam int CTRL_DECAY_W = 2;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
   localparam logic [1:0] DECAY_SLOW = 2'h0;
   localparam logic [1:0] DECAY_FAST = 2'h1;
   localparam logic [1:0] DECAY_MIXED = 2'h2;

   // ==========================================================
   // bus encodings
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ==========================================================
   // types
   typedef struct packed {
      logic high_side_1;
      logic high_side_2;
      logic low_side_1;
      logic low_side_2;
   } hbd_gate_s;

   typedef enum logic [2:0] {
      BR_OFF,
      BR_CHARGE,
      BR_FAST,
      BR_SLOW,
      BR_BRAKE_HI
   } hbd_bridge_e;

   localparam hbd_gate_s GATE_OFF = 4'h0;

endpackage

/* File: rtl/hbd_ctrl.sv */
// dual h-bridge drive controller: blanking, decay sequencing, dead time,
// over-temperature and over-current shutdown, sleep and logic clear
// assumes pins and comparator outputs are asynchronous to i_clk and that
// software reaches the control and status words over ahb-lite
// Function
// R1 - start blanking on every change of a channel's drive inputs
// R2 - sleep input low sleeps and stops regulator; high runs normally
// R3 - entering sleep clears latched faults and releases the fault flag
// R4 - in sleep halt the oscillator and hold every bridge switch off
// R5 - logic clear input low holds internal logic cleared; high runs
// R6 - dead time on every switch change, conducting switches off first
// R7 - positive current: charge hs1+ls2, fast hs2+ls1, slow both low sides
// R8 - negative current: charge hs2+ls1, fast hs1+ls2, slow both low sides
// R9 - current is regulated only through charge, fast decay and slow decay
// R10 - confirmed over-temperature turns off all channels at once
// R11 - over-temperature shutdown recovers by itself when temperature returns
// R12 - over-temperature must persist a dead-band time before acting
// R13 - over-current shorter than a dead-band time is ignored
// R14 - confirmed over-current turns off both channels
// R15 - over-current shutdown is latched until cleared
// R16 - fault flag released normally, pulled low during any shutdown
// R17 - latched fault cleared by supply power cycle or logic clear
// R18 - equal inputs brake; input 1 high drives forward, input 2 reverse
// R19 - mixed decay starts fast, goes slow after 75 % of pwm cycle
// R20 - current-limit comparator masked during each blanking interval

`timescale 1ns/100ps

module hbd_ctrl
   import hbd_pkg::*;
#(
   parameter int CH = 2,
   parameter int ADDR_W = 8
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [CH-1:0] i_drive_input_1,
   input wire logic [CH-1:0] i_drive_input_2,
   input wire logic [CH-1:0] i_current_limit,
   input wire logic i_sleep_n,
   input wire logic i_clear_n,
   input wire logic i_overtemp,
   input wire logic i_overcurrent,
   input wire logic i_hsel,
   input wire logic [ADDR_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output hbd_gate_s [CH-1:0] o_gate,
   output logic o_fault_flag_n_o,
   output logic o_fault_flag_n_oe_n,
   output logic o_regulator_en,
   output logic o_osc_run
);

   // ==========================================================
   // functions
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
      reg_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

   // dead-band count: restarts when idle or the input drops, holds at the limit
   function automatic logic [CNT_W-1:0] deg_step(input logic en, input logic [CNT_W-1:0] cnt);
      if (!en) begin
         deg_step = CNT_ZERO;
      end else if (cnt == DEG_LD) begin
         deg_step = cnt;
      end else begin
         deg_step = cnt + CNT_ONE;
      end
   endfunction

   // gate pattern for a bridge mode and current direction
   function automatic hbd_gate_s gate_of(input hbd_bridge_e mode, input logic neg);
      hbd_gate_s g;
      g = GATE_OFF;
      case (mode)
         BR_CHARGE: begin
            g.high_side_1 = ~neg; // see R7
            g.low_side_2 = ~neg;
            g.high_side_2 = neg; // see R8
            g.low_side_1 = neg;
         end
         BR_FAST: begin
            g.high_side_2 = ~neg; // see R7
            g.low_side_1 = ~neg;
            g.high_side_1 = neg; // see R8
            g.low_side_2 = neg;
         end
         BR_SLOW: begin
            g.low_side_1 = 1'b1; // see R7
            g.low_side_2 = 1'b1; // see R8
         end
         BR_BRAKE_HI: begin
            g.high_side_1 = 1'b1;
            g.high_side_2 = 1'b1;
         end
         default: begin
            g = GATE_OFF;
         end
      endcase
      gate_of = g;
   endfunction

   // ==========================================================
   // pin synchronisers: three stages, accepted when stages two and three agree
   localparam int SW = 3 * CH + 4;
   logic [SW-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
   wire [SW-1:0] raw_w = {i_drive_input_1, i_drive_input_2, i_current_limit,
                          i_sleep_n, i_clear_n, i_overtemp, i_overcurrent};
   wire [SW-1:0] flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         flt_reg <= '0;
      end else begin
         s1_reg <= raw_w;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         flt_reg <= flt_next;
      end
   end

   wire [CH-1:0] in1_f = flt_reg[3*CH+3 -: CH];
   wire [CH-1:0] in2_f = flt_reg[2*CH+3 -: CH];
   wire [CH-1:0] lim_f = flt_reg[CH+3 -: CH];
   wire sleep_n_f = flt_reg[3];
   wire clear_n_f = flt_reg[2];
   wire ot_f = flt_reg[1];
   wire oc_f = flt_reg[0];

   // logic runs only when awake and not cleared; the oscillator pin follows sleep alone
   wire run_w = sleep_n_f & clear_n_f; // see R2, R4, R5

   // ==========================================================
   // fault detection
   logic [CNT_W-1:0] ot_cnt_reg, oc_cnt_reg;
   logic ot_active_reg, oc_latch_reg;
   wire oc_hit = (oc_cnt_reg == DEG_LD);
   wire [CNT_W-1:0] ot_cnt_next = deg_step(run_w & ot_f, ot_cnt_reg); // see R12
   wire [CNT_W-1:0] oc_cnt_next = deg_step(run_w & oc_f, oc_cnt_reg); // see R13
   // temperature shutdown follows the comparator once confirmed
   wire ot_active_next = (ot_cnt_next == DEG_LD); // see R10, R11
   // sleep or logic clear drop the latch; the level holds it cleared
   wire oc_latch_next = run_w & (oc_latch_reg | oc_hit); // see R15, R3, R17
   wire fault_w = ot_active_reg | oc_latch_reg;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ot_cnt_reg <= CNT_ZERO;
         oc_cnt_reg <= CNT_ZERO;
         ot_active_reg <= 1'b0;
         oc_latch_reg <= 1'b0;
      end else begin
         ot_cnt_reg <= ot_cnt_next;
         oc_cnt_reg <= oc_cnt_next;
         ot_active_reg <= ot_active_next;
         oc_latch_reg <= oc_latch_next;
      end
   end

   // bridges may drive only while running and free of faults
   wire drive_en = run_w & ~fault_w; // see R10, R14

   // ==========================================================
   // chopping cycle
   logic [CNT_W-1:0] chop_cnt_reg;
   wire chop_wrap = (chop_cnt_reg == CHOP_LAST);
   wire [CNT_W-1:0] chop_cnt_next = (!run_w || chop_wrap) ? CNT_ZERO :
                                    chop_cnt_reg + CNT_ONE; // see R4
   wire cyc_start = run_w & (chop_cnt_reg == CNT_ZERO);
   wire mix_fast = (chop_cnt_reg < MIX_LD);

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         chop_cnt_reg <= CNT_ZERO;
      end else begin
         chop_cnt_reg <= chop_cnt_next;
      end
   end

   // ==========================================================
   // control register fields
   logic [31:0] ctrl_reg;
   wire [1:0] decay_sel = ctrl_reg[CTRL_DECAY_LSB +: CTRL_DECAY_W];
   wire sel_fast = (decay_sel == DECAY_FAST);
   wire sel_slow = (decay_sel == DECAY_SLOW);
   // mixed starts fast and turns slow late in the cycle
   wire use_fast = sel_fast | (~sel_slow & mix_fast); // see R19

   // ==========================================================
   // per-channel bridge control
   logic [CH-1:0] blank_vec;
   logic [CH-1:0] decay_vec;

   genvar c;
   generate
      for (c = 0; c < CH; c++) begin : g_ch
         logic [1:0] prev_reg;
         logic in_decay_reg;
         logic [CNT_W-1:0] blank_cnt_reg;
         logic [CNT_W-1:0] dead_cnt_reg;
         hbd_gate_s gate_reg;

         wire [1:0] pair = {in1_f[c], in2_f[c]};
         wire changed = run_w & (pair != prev_reg); // see R1
         wire drive = in1_f[c] ^ in2_f[c]; // see R18
         wire neg = in2_f[c];
         wire blanking = (blank_cnt_reg != CNT_ZERO);
         // limit comparator ignored while blanking
         wire trip = drive & ~blanking & lim_f[c] & ~in_decay_reg; // see R20
         wire blank_start = changed | (cyc_start & in_decay_reg); // see R1
         wire [CNT_W-1:0] blank_next = !run_w ? CNT_ZERO :
                                       blank_start ? BLANK_LD :
                                       blanking ? blank_cnt_reg - CNT_ONE : CNT_ZERO;
         wire decay_next = (!run_w || cyc_start || changed) ? 1'b0 :
                           trip ? 1'b1 : in_decay_reg;

         // only charge, fast and slow are used to regulate
         wire hbd_bridge_e decay_mode = use_fast ? BR_FAST : BR_SLOW; // see R9
         wire hbd_bridge_e brake_mode = in1_f[c] ? BR_BRAKE_HI : BR_SLOW; // see R18
         wire hbd_bridge_e mode = !drive_en ? BR_OFF :
                                  !drive ? brake_mode :
                                  in_decay_reg ? decay_mode : BR_CHARGE; // see R4, R9
         wire hbd_gate_s target = gate_of(mode, neg);

         // break before make: drop conflicting switches, wait, then turn on
         wire [3:0] off_part = gate_reg & target;
         wire conflict = ((gate_reg & ~target) != 4'h0);
         wire dead_busy = (dead_cnt_reg != CNT_ZERO);
         wire hbd_gate_s gate_next = (conflict || dead_busy) ? hbd_gate_s'(off_part) :
                                     target; // see R6
         wire [CNT_W-1:0] dead_next = conflict ? DEAD_LD :
                                      dead_busy ? dead_cnt_reg - CNT_ONE : CNT_ZERO; // see R6

         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               prev_reg <= 2'h0;
               in_decay_reg <= 1'b0;
               blank_cnt_reg <= CNT_ZERO;
               dead_cnt_reg <= CNT_ZERO;
               gate_reg <= GATE_OFF;
            end else begin
               prev_reg <= pair;
               in_decay_reg <= decay_next;
               blank_cnt_reg <= blank_next;
               dead_cnt_reg <= dead_next;
               gate_reg <= gate_next;
            end
         end

         assign blank_vec[c] = blanking;
         assign decay_vec[c] = in_decay_reg;
         assign o_gate[c] = gate_reg;
      end
   endgenerate

   // ==========================================================
   // pin outputs
   logic fault_oe_n_reg, fault_o_reg, reg_en_reg, osc_run_reg;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fault_oe_n_reg <= 1'b1;
         fault_o_reg <= 1'b0;
      end else begin
         fault_oe_n_reg <= ~fault_w; // see R16
         fault_o_reg <= 1'b0;
      end
   end

   // ==========================================================
   // sleep outputs: regulator and oscillator stop while asleep
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         reg_en_reg <= 1'b0;
         osc_run_reg <= 1'b0;
      end else begin
         reg_en_reg <= sleep_n_f; // see R2
         osc_run_reg <= sleep_n_f; // see R4
      end
   end

   assign o_fault_flag_n_oe_n = fault_oe_n_reg;
   assign o_fault_flag_n_o = fault_o_reg;
   assign o_regulator_en = reg_en_reg;
   assign o_osc_run = osc_run_reg;

   // ==========================================================
   // ahb-lite slave, zero wait states, always okay
   logic dp_wr_reg;
   logic [ADDR_W-1:0] dp_addr_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg, hresp_reg;

   wire ahb_take = i_hsel & i_htrans[HTRANS_ACTIVE_BIT] & i_hready;
   wire ahb_wr_take = ahb_take & i_hwrite & (i_hsize == HSIZE_WORD);
   wire ahb_rd_take = ahb_take & ~i_hwrite;
   wire [31:0] status_w = 32'({decay_vec, blank_vec, ~clear_n_f, ~sleep_n_f,
                               oc_latch_reg, ot_active_reg});
   wire [31:0] rd_w = reg_hit(i_haddr, CTRL_OFS) ? ctrl_reg :
                      reg_hit(i_haddr, STAT_OFS) ? status_w : RD_ZERO;
   wire ctrl_wr = dp_wr_reg & reg_hit(dp_addr_reg, CTRL_OFS);
   wire [31:0] ctrl_next = ctrl_wr ? (i_hwdata & CTRL_MASK) : ctrl_reg;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dp_wr_reg <= 1'b0;
         dp_addr_reg <= '0;
         hrdata_reg <= RD_ZERO;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         dp_wr_reg <= ahb_wr_take;
         dp_addr_reg <= i_haddr;
         hrdata_reg <= ahb_rd_take ? rd_w : RD_ZERO;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end
   end

   // ==========================================================
   // control word: written at the end of the data phase
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   assign o_hrdata = hrdata_reg;
   assign o_hreadyout = hreadyout_reg;
   assign o_hresp = hresp_reg;

endmodule

/* File: tb/hbd_ctrl_monitor.sv */
// port assertions for the dual bridge drive controller
// bound to hbd_ctrl from tb_top; one clock domain
`timescale 1ns/100ps
module hbd_ctrl_monitor
   import hbd_pkg::*;
#(
   parameter int CH = 2
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_sleep_n,
   input wire logic i_clear_n,
   input wire logic i_overtemp,
   input wire logic i_overcurrent,
   input wire hbd_gate_s [CH-1:0] o_gate,
   input wire logic o_fault_flag_n_oe_n,
   input wire logic o_osc_run,
   input wire logic o_regulator_en
);
   // =====
   // fault run lengths while awake and not cleared
   logic [7:0] ot_reg;
   logic [7:0] oc_reg;
   logic seen_reg;
   logic shoot;
   wire run = i_sleep_n & i_clear_n;
   wire [7:0] ot_next = (i_overtemp & run) ? ot_reg + {7'h00, ot_reg != 8'hff} : 8'h00;
   wire [7:0] oc_next = (i_overcurrent & run) ? oc_reg + {7'h00, oc_reg != 8'hff} : 8'h00;
   wire seen_next = run & (seen_reg | (oc_reg >= 8'h5a));
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ot_reg <= 8'h00;
         oc_reg <= 8'h00;
         seen_reg <= 1'b0;
      end else begin
         ot_reg <= ot_next;
         oc_reg <= oc_next;
         seen_reg <= seen_next;
      end
   end
   always_comb begin
      shoot = 1'b0;
      for (int c = 0; c < CH; c++) begin
         shoot = shoot | (o_gate[c].high_side_1 & o_gate[c].low_side_1)
            | (o_gate[c].high_side_2 & o_gate[c].low_side_2);
      end
   end
   // =====
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_sleep_gates: assert property (
      (!i_sleep_n)[*7] |-> o_gate == '0) else $error("gates on in sleep");
   a_sleep_clock: assert property (
      (!i_sleep_n)[*7] |-> !o_osc_run && !o_regulator_en) else $error("clock runs in sleep");
   a_no_shoot: assert property (
      !shoot) else $error("shoot-through");
   a_dead_gap: assert property (
      $fell(o_gate[0].high_side_1) |-> (!o_gate[0].low_side_1)[*5]) else $error("no dead time");
   a_ot_off: assert property (
      ot_reg >= 8'h5a |-> o_gate == '0) else $error("gates on in overtemp");
   a_ot_flag: assert property (
      ot_reg >= 8'h5a |-> !o_fault_flag_n_oe_n) else $error("flag idle in overtemp");
   a_fault_deadband: assert property (
      $fell(o_fault_flag_n_oe_n) |-> ot_reg >= 8'h46 || oc_reg >= 8'h46)
      else $error("fault without dead band");
   a_oc_latch: assert property (
      seen_reg |-> o_gate == '0 && !o_fault_flag_n_oe_n) else $error("latch lost");
   a_ot_recover: assert property (
      (!i_overtemp && !i_overcurrent && !seen_reg && run)[*8] |-> o_fault_flag_n_oe_n)
      else $error("no recovery");
   c_ot_trip: cover property (ot_reg == 8'h5a);
   c_oc_latch: cover property ($rose(seen_reg));
   c_dead: cover property ($fell(o_gate[0].high_side_1));
endmodule

/* File: tb/hbd_host_model.sv */
// host side: direction, sleep and clear pins, pulled-up fault line
// tasks drive after a rising edge by non-blocking assignment
`timescale 1ns/100ps
module hbd_host_model
   import hbd_pkg::*;
#(
   parameter int CH = 2
) (
   input wire logic i_clk,
   input wire logic i_fault_o,
   input wire logic i_fault_oe_n,
   output logic [CH-1:0] o_drive_input_1,
   output logic [CH-1:0] o_drive_input_2,
   output logic o_sleep_n,
   output logic o_clear_n,
   output logic o_fault_pin
);
   // released flag line floats to the pull-up level
   assign o_fault_pin = i_fault_oe_n ? 1'b1 : i_fault_o;
   initial begin
      o_drive_input_1 = '0;
      o_drive_input_2 = '0;
      o_sleep_n = 1'b1;
      o_clear_n = 1'b1;
   end
   task automatic set_drive(input int ch, input logic a, input logic b);
      @(posedge i_clk);
      o_drive_input_1[ch] <= a;
      o_drive_input_2[ch] <= b;
   endtask
   task automatic set_pins(input logic s, input logic c);
      @(posedge i_clk);
      o_sleep_n <= s;
      o_clear_n <= c;
   endtask
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the dual bridge drive controller
// assumes the host model, the ahb-lite tasks and the main sequence below drive every input
`timescale 1ns/100ps
module tb_top
   import hbd_pkg::*;
;
   localparam int CH = 2;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ot = 1'b0;
   logic oc = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [CH-1:0] lim = '0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] hsize = HSIZE_WORD;
   logic hresp;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hready, fo, foe_n, fpin, slp_n, clr_n;
   logic [CH-1:0] in1, in2;
   logic [1:0] pwr;
   hbd_gate_s [CH-1:0] gate;
   int err_count = 0;
   int checks_done = 0;

   hbd_ctrl #(.CH(CH), .ADDR_W(8)) hbd_ctrl_inst (
      .i_clk(clk), .i_rstn(rstn), .i_drive_input_1(in1), .i_drive_input_2(in2),
      .i_current_limit(lim), .i_sleep_n(slp_n), .i_clear_n(clr_n),
      .i_overtemp(ot), .i_overcurrent(oc), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp), .o_gate(gate), .o_fault_flag_n_o(fo),
      .o_fault_flag_n_oe_n(foe_n), .o_regulator_en(pwr[0]), .o_osc_run(pwr[1])
   );
   hbd_host_model #(.CH(CH)) host (
      .i_clk(clk), .i_fault_o(fo), .i_fault_oe_n(foe_n), .o_drive_input_1(in1),
      .o_drive_input_2(in2), .o_sleep_n(slp_n), .o_clear_n(clr_n), .o_fault_pin(fpin)
   );

   initial begin
      forever #20 clk = ~clk;
   end

   // =====
   // tasks
   task automatic wrap_up;
      $display("mismatches %0d, checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wait_gate(input int c, input logic [3:0] e);
      int n;
      n = 0;
      while (gate[c] !== e && n < 1200) begin
         @(posedge clk);
         n++;
      end
      check(32'(gate[c]), 32'(e));
   endtask

   // =====
   // main sequence
   initial begin
      step(12);
      rstn <= 1'b1;
      step(10);
      bus(CTRL_OFS, 1'b0, 32'h0);
      check(rd, CTRL_RESET);
      bus(8'h10, 1'b1, 32'h5);
      bus(8'h10, 1'b0, 32'h0);
      check(rd, RD_ZERO);
      check(32'(hresp), 32'h0);
      hsize <= 3'h0;
      bus(CTRL_OFS, 1'b1, 32'h1);
      hsize <= HSIZE_WORD;
      bus(CTRL_OFS, 1'b0, 32'h0);
      check(rd, CTRL_RESET);
      wait_gate(0, 4'h3);
      host.set_drive(1, 1'b1, 1'b1);
      wait_gate(1, 4'hc);
      host.set_drive(0, 1'b1, 1'b0);
      lim <= 2'b01;
      step(20);
      check(32'(gate[0]), 32'h9);
      bus(STAT_OFS, 1'b0, 32'h0);
      check(rd & 32'h10, 32'h10);
      wait_gate(0, 4'h6);
      wait_gate(0, 4'h3);
      bus(CTRL_OFS, 1'b1, 32'(DECAY_FAST));
      host.set_drive(1, 1'b0, 1'b1);
      lim <= 2'b11;
      wait_gate(1, 4'h6);
      wait_gate(1, 4'h9);
      bus(CTRL_OFS, 1'b1, 32'(DECAY_SLOW));
      wait_gate(1, 4'h3);
      lim <= 2'b00;
      wait_gate(0, 4'h9);
      ot <= 1'b1;
      step(40);
      ot <= 1'b0;
      step(10);
      check(32'(fpin), 32'h1);
      ot <= 1'b1;
      step(100);
      check(32'(gate), 32'h0);
      check(32'(fpin), 32'h0);
      ot <= 1'b0;
      step(12);
      check(32'(fpin), 32'h1);
      wait_gate(0, 4'h9);
      oc <= 1'b1;
      step(40);
      oc <= 1'b0;
      step(10);
      check(32'(fpin), 32'h1);
      oc <= 1'b1;
      step(100);
      check(32'(gate), 32'h0);
      oc <= 1'b0;
      step(100);
      check(32'(gate), 32'h0);
      bus(STAT_OFS, 1'b0, 32'h0);
      check(rd & 32'h2, 32'h2);
      host.set_pins(1'b1, 1'b0);
      step(10);
      bus(STAT_OFS, 1'b0, 32'h0);
      check(rd & 32'h8, 32'h8);
      host.set_pins(1'b1, 1'b1);
      step(20);
      check(32'(fpin), 32'h1);
      oc <= 1'b1;
      step(100);
      oc <= 1'b0;
      host.set_pins(1'b0, 1'b1);
      step(10);
      check(32'(pwr), 32'h0);
      check(32'(gate), 32'h0);
      check(32'(fpin), 32'h1);
      host.set_pins(1'b1, 1'b1);
      step(10);
      check(32'(pwr), 32'h3);
      wrap_up;
   end

   initial begin
      step(30000);
      err_count++;
      $display("watchdog expired");
      wrap_up;
   end
endmodule

bind hbd_ctrl hbd_ctrl_monitor #(.CH(CH)) hbd_ctrl_monitor_inst (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_sleep_n(i_sleep_n), .i_clear_n(i_clear_n),
   .i_overtemp(i_overtemp), .i_overcurrent(i_overcurrent), .o_gate(o_gate),
   .o_fault_flag_n_oe_n(o_fault_flag_n_oe_n), .o_osc_run(o_osc_run),
   .o_regulator_en(o_regulator_en)
);
